// *** hdl/ecl_pkg.sv ***
// package for the encoder counter latch channel: word indices, fields, timing
package ecl_pkg;
  // word indices of the channel word port
  localparam logic [3:0] IDX_STATUS = 4'h0;
  localparam logic [3:0] IDX_COUNT_HI = 4'h1;
  localparam logic [3:0] IDX_COUNT_LO = 4'h2;
  localparam logic [3:0] IDX_CFG4 = 4'h4;
  localparam logic [3:0] IDX_CFG5 = 4'h5;
  localparam logic [3:0] IDX_CFG6 = 4'h6;
  localparam logic [3:0] IDX_CFG7 = 4'h7;
  localparam logic [3:0] IDX_CTRL = 4'h8;
  // status bit positions
  localparam int ST_REF = 0;
  localparam int ST_ENSW = 1;
  localparam int ST_B = 2;
  localparam int ST_A = 3;
  localparam int ST_CMP = 4;
  localparam int ST_SUPPLY = 5;
  localparam int ST_TOGGLE = 6;
  localparam int ST_HOMED = 7;
  localparam int ST_FALL = 10;
  localparam int ST_RISE = 11;
  // control bit positions
  localparam int CT_SELECT = 8;
  localparam int CT_FILT_START = 9;
  localparam int CT_ARM_FALL = 10;
  localparam int CT_ARM_RISE = 11;
  localparam int CT_HOME = 12;
  localparam int CT_SW_INV = 13;
  // control bits that software may set
  localparam logic [15:0] CTRL_MASK = 16'h3f00;
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  localparam logic [31:0] VALUE_RESET = 32'h0000_0000;
  // timing
  localparam int CLK_HZ = 10_000_000;
  localparam int LATCH_MAX_NS = 50_000;
  localparam int FORCE_MAX_NS = 1_000_000;
  localparam int LATCH_MAX_CYC = LATCH_MAX_NS / (1_000_000_000 / CLK_HZ);
  localparam int FORCE_MAX_CYC = FORCE_MAX_NS / (1_000_000_000 / CLK_HZ);
  localparam int FILT_LEN = 3;
endpackage : ecl_pkg

// *** hdl/ecl_quad.sv ***
// quadrature decoder with 4-fold evaluation and a loadable 32-bit counter
`timescale 1ns/1ps
module ecl_quad
  import ecl_pkg::*;
#(
  parameter int WIDTH = 32
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // synchronised encoder tracks
  input wire logic a_sync,
  input wire logic b_sync,
  // counter load
  input wire logic load,
  input wire logic [WIDTH-1:0] load_value,
  // count
  output logic [WIDTH-1:0] count
);
  logic a_q;
  logic b_q;
  logic [WIDTH-1:0] next_count;
  wire moved = (a_sync ^ a_q) | (b_sync ^ b_q);
  // direction from gray sequence: new a xor old b
  wire up = a_sync ^ b_q;

  // next counter value, load wins over counting
  always_comb begin
    next_count = count;
    if (load) begin
      next_count = load_value;
    end else if (moved) begin
      next_count = up ? count + 1'b1 : count - 1'b1;
    end
  end

  // track history and counter
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      a_q <= 1'b0;
      b_q <= 1'b0;
      count <= '0;
    end else begin
      a_q <= a_sync;
      b_q <= b_sync;
      count <= next_count;
    end
  end
endmodule : ecl_quad

// *** hdl/ecl_channel.sv ***
// encoder channel: status, counter, reference latches, homing and control word
`timescale 1ns/1ps
module ecl_channel
  import ecl_pkg::*;
#(
  parameter int FILT = FILT_LEN
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // encoder side pins
  input wire logic enc_a,
  input wire logic enc_b,
  input wire logic ref_pulse,
  input wire logic ref_switch,
  input wire logic supply_ok,
  // module configuration held elsewhere
  input wire logic cfg_unsigned,
  input wire logic cmp_enable,
  // word port
  input wire logic [3:0] word_idx,
  input wire logic word_wr,
  input wire logic [15:0] word_wdata,
  output logic [15:0] word_rdata,
  // comparator
  output logic cmp_out
);
  // two-flop synchronisers for pins
  logic [4:0] sync1;
  logic [4:0] sync2;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sync1 <= '0;
      sync2 <= '0;
    end else begin
      sync1 <= {supply_ok, ref_switch, ref_pulse, enc_b, enc_a};
      sync2 <= sync1;
    end
  end
  wire a_s = sync2[0];
  wire b_s = sync2[1];
  wire ref_s = sync2[2];
  wire sw_s = sync2[3];
  wire sup_s = sync2[4];

  // registers
  logic [15:0] encoder_control;
  logic [31:0] thr_one_wr;
  logic [31:0] thr_two_wr;
  logic [31:0] min_diff;
  logic [31:0] force_value;
  logic [31:0] rising_latch_capture;
  logic [31:0] falling_latch_capture;
  logic [31:0] rise_cmp_base;
  logic [31:0] fall_cmp_base;
  logic rise_done;
  logic fall_done;
  logic homed;
  logic home_toggle;
  logic home_armed;
  logic sw_q;
  logic filt_state;
  logic [$clog2(FILT+1)-1:0] filt_cnt;
  logic ctrl_q8;
  logic ctrl_q12;
  logic ctrl_q10;
  logic ctrl_q11;
  logic [31:0] count;

  // write strobes per word
  wire wr_c4 = word_wr && word_idx == IDX_CFG4;
  wire wr_c5 = word_wr && word_idx == IDX_CFG5;
  wire wr_c6 = word_wr && word_idx == IDX_CFG6;
  wire wr_c7 = word_wr && word_idx == IDX_CFG7;
  wire wr_ct = word_wr && word_idx == IDX_CTRL;

  // control edges
  wire sel_rise = encoder_control[CT_SELECT] & ~ctrl_q8;
  wire home_rise = encoder_control[CT_HOME] & ~ctrl_q12;
  wire arm_rise_on = encoder_control[CT_ARM_RISE] & ~ctrl_q11;
  wire arm_fall_on = encoder_control[CT_ARM_FALL] & ~ctrl_q10;

  // homing switch with selectable polarity
  wire sw_eff = sw_s ^ encoder_control[CT_SW_INV];
  wire home_hit = home_armed & sw_eff & ~sw_q;

  // reference input filter: state follows input after FILT+1 stable cycles
  wire filt_flip = (ref_s != filt_state) && (filt_cnt == FILT[$bits(filt_cnt)-1:0]);
  wire ref_rise = filt_flip & ref_s;
  wire ref_fall = filt_flip & ~ref_s;

  // latching yields to homing and comparator sharing the input
  wire latch_ok = ~home_armed & ~cmp_enable;
  wire [31:0] rise_diff = count - rise_cmp_base;
  wire [31:0] fall_diff = count - fall_cmp_base;
  wire rise_pass = (min_diff == VALUE_RESET) || (rise_diff > min_diff);
  wire fall_pass = (min_diff == VALUE_RESET) || (fall_diff > min_diff);
  wire take_rise = encoder_control[CT_ARM_RISE] & ~rise_done & ref_rise
                   & latch_ok & rise_pass;
  wire take_fall = encoder_control[CT_ARM_FALL] & ~fall_done & ref_fall
                   & latch_ok & fall_pass;

  // counter
  ecl_quad #(.WIDTH(32)) u_quad (
    .clk_sys(clk_sys),
    .rst(rst),
    .a_sync(a_s),
    .b_sync(b_s),
    .load(home_hit),
    .load_value(force_value),
    .count(count)
  );

  // control word and edge history
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      encoder_control <= CTRL_RESET;
      ctrl_q8 <= 1'b0;
      ctrl_q10 <= 1'b0;
      ctrl_q11 <= 1'b0;
      ctrl_q12 <= 1'b0;
    end else begin
      if (wr_ct) encoder_control <= word_wdata & CTRL_MASK;
      ctrl_q8 <= encoder_control[CT_SELECT];
      ctrl_q10 <= encoder_control[CT_ARM_FALL];
      ctrl_q11 <= encoder_control[CT_ARM_RISE];
      ctrl_q12 <= encoder_control[CT_HOME];
    end
  end

  // written values; bit 8 rise moves them to difference and force
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      thr_one_wr <= VALUE_RESET;
      thr_two_wr <= VALUE_RESET;
      min_diff <= VALUE_RESET;
      force_value <= VALUE_RESET;
    end else begin
      if (wr_c4) thr_one_wr[31:16] <= word_wdata;
      if (wr_c5) thr_one_wr[15:0] <= word_wdata;
      if (wr_c6) thr_two_wr[31:16] <= word_wdata;
      if (wr_c7) thr_two_wr[15:0] <= word_wdata;
      if (sel_rise) begin
        min_diff <= thr_one_wr;
        force_value <= thr_two_wr;
      end
    end
  end

  // reference filter, seeded by control bit 9 on write
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      filt_state <= 1'b0;
      filt_cnt <= '0;
    end else if (wr_ct) begin
      filt_state <= word_wdata[CT_FILT_START];
      filt_cnt <= '0;
    end else if (ref_s == filt_state) begin
      filt_cnt <= '0;
    end else if (filt_flip) begin
      filt_state <= ref_s;
      filt_cnt <= '0;
    end else begin
      filt_cnt <= filt_cnt + 1'b1;
    end
  end

  // latch capture, done flags cleared when arming bit drops
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rising_latch_capture <= VALUE_RESET;
      falling_latch_capture <= VALUE_RESET;
      rise_cmp_base <= VALUE_RESET;
      fall_cmp_base <= VALUE_RESET;
      rise_done <= 1'b0;
      fall_done <= 1'b0;
    end else begin
      if (arm_rise_on) rise_cmp_base <= count;
      if (arm_fall_on) fall_cmp_base <= count;
      if (take_rise) begin
        rising_latch_capture <= count;
        rise_done <= 1'b1;
      end else if (!encoder_control[CT_ARM_RISE]) begin
        rise_done <= 1'b0;
      end
      if (take_fall) begin
        falling_latch_capture <= count;
        fall_done <= 1'b1;
      end else if (!encoder_control[CT_ARM_FALL]) begin
        fall_done <= 1'b0;
      end
    end
  end

  // homing sequence
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      homed <= 1'b0;
      home_toggle <= 1'b0;
      home_armed <= 1'b0;
      sw_q <= 1'b0;
    end else begin
      sw_q <= sw_eff;
      if (home_hit) begin
        home_armed <= 1'b0;
        homed <= 1'b1;
        home_toggle <= ~home_toggle;
      end else if (home_rise) begin
        home_armed <= 1'b1;
        homed <= 1'b0;
      end
    end
  end

  // threshold ordering: signed mode sorts, unsigned keeps order
  wire swap = ~cfg_unsigned && ($signed(thr_one_wr) > $signed(thr_two_wr));
  wire [31:0] thr_lo = swap ? thr_two_wr : thr_one_wr;
  wire [31:0] thr_hi = swap ? thr_one_wr : thr_two_wr;
  wire in_win = cfg_unsigned ? (count >= thr_lo && count <= thr_hi)
              : ($signed(count) >= $signed(thr_lo) && $signed(count) <= $signed(thr_hi));
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) cmp_out <= 1'b0;
    else cmp_out <= cmp_enable & in_win & ~home_armed;
  end

  // status word
  wire [15:0] status_word = {4'h0, rise_done, fall_done, 2'b00, homed, home_toggle,
                             sup_s, cmp_out, a_s, b_s, sw_s, ref_s};

  // read mux, registered
  logic [15:0] next_rdata;
  always_comb begin
    case (word_idx)
      IDX_STATUS: next_rdata = status_word;
      IDX_COUNT_HI: next_rdata = count[31:16];
      IDX_COUNT_LO: next_rdata = count[15:0];
      IDX_CFG4: next_rdata = rising_latch_capture[31:16];
      IDX_CFG5: next_rdata = rising_latch_capture[15:0];
      IDX_CFG6: next_rdata = falling_latch_capture[31:16];
      IDX_CFG7: next_rdata = falling_latch_capture[15:0];
      IDX_CTRL: next_rdata = encoder_control;
      default: next_rdata = 16'h0000;
    endcase
  end
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) word_rdata <= 16'h0000;
    else word_rdata <= next_rdata;
  end
endmodule : ecl_channel

// *** sim/ecl_channel_asserts.sv ***
// checker of the channel word port
`timescale 1ns/1ps
module ecl_channel_asserts
  import ecl_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // pins
  input wire logic ref_pulse,
  input wire logic ref_switch,
  input wire logic supply_ok,
  input wire logic cmp_enable,
  // word port
  input wire logic [3:0] word_idx,
  input wire logic word_wr,
  input wire logic [15:0] word_wdata,
  input wire logic [15:0] word_rdata,
  input wire logic cmp_out
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  logic [15:0] ctrl;
  logic rd_st;
  logic wr_ct;
  // shadow of the control word
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) ctrl <= 16'h0000;
    else if (wr_ct) ctrl <= word_wdata;
  end
  // access decode
  assign rd_st = word_idx == IDX_STATUS && !word_wr;
  assign wr_ct = word_wr && word_idx == IDX_CTRL;
  pin_live_a: assert property (($stable(ref_pulse) && $stable(ref_switch))[*4]
    ##0 rd_st |=> word_rdata[1:0] == {$past(ref_switch), $past(ref_pulse)})
    else $error("pin bits wrong");
  supply_a: assert property ($stable(supply_ok)[*4] ##0 rd_st
    |=> word_rdata[ST_SUPPLY] == $past(supply_ok)) else $error("supply bit wrong");
  masked_a: assert property (rd_st |=> word_rdata[9:8] == 2'h0 && word_rdata[15:12] == 4'h0)
    else $error("undefined bits set");
  ctrl_echo_a: assert property (wr_ct ##1 word_idx == IDX_CTRL && !word_wr
    |=> word_rdata == ($past(word_wdata, 2) & CTRL_MASK)) else $error("control readback");
  home_clr_a: assert property (wr_ct && word_wdata[CT_HOME] && !ctrl[CT_HOME] ##2 rd_st
    |=> !word_rdata[ST_HOMED]) else $error("homed not cleared");
  rise_idle_a: assert property ((!ctrl[CT_ARM_RISE])[*3] ##0 rd_st
    |=> !word_rdata[ST_RISE]) else $error("rise flag unarmed");
  fall_idle_a: assert property ((!ctrl[CT_ARM_FALL])[*3] ##0 rd_st
    |=> !word_rdata[ST_FALL]) else $error("fall flag unarmed");
  cmp_off_a: assert property (!cmp_enable [*2] |-> !cmp_out) else $error("comparator on");
  // main scenarios reached
  cover property (rd_st ##1 word_rdata[ST_RISE]);
  cover property (rd_st ##1 word_rdata[ST_HOMED]);
  cover property (wr_ct && word_wdata[CT_SELECT]);
  cover property (cmp_enable ##1 cmp_out);
endmodule : ecl_channel_asserts

// *** sim/ecl_enc_model.sv ***
// quadrature encoder with reference pulse and enable switch
`timescale 1ns/1ps
module ecl_enc_model (
  // clock
  input wire logic clk_sys,
  // bench commands
  input wire logic step,
  input wire logic dir,
  input wire logic ref_lvl,
  input wire logic sw_lvl,
  // encoder pins
  output logic enc_a,
  output logic enc_b,
  output logic ref_pulse,
  output logic ref_switch
);
  logic [1:0] phase = 2'h0;
  // one gray state per step, dir reverses
  always @(posedge clk_sys) if (step) phase <= phase + (dir ? 2'h3 : 2'h1);
  // pins
  assign enc_a = phase[1];
  assign enc_b = phase[1] ^ phase[0];
  assign ref_pulse = ref_lvl;
  assign ref_switch = sw_lvl;
endmodule : ecl_enc_model

// *** sim/tb_top.sv ***
// testbench top: channel scenarios and verdict
`timescale 1ns/1ps
module tb_top
  import ecl_pkg::*;
;
  localparam logic [31:0] FORCE = 32'h0001_0002;
  logic clk_sys = 1'b0, rst = 1'b1, step = 1'b0, dir = 1'b0;
  logic ref_lvl = 1'b0, sw_lvl = 1'b0, supply_ok = 1'b1, word_wr = 1'b0;
  logic cfg_unsigned = 1'b0, cmp_enable = 1'b0;
  logic [3:0] word_idx = 4'h0;
  logic [15:0] word_wdata = 16'h0000;
  logic [15:0] word_rdata;
  logic enc_a, enc_b, ref_pulse, ref_switch, cmp_out;
  logic [15:0] v;
  logic [31:0] c;
  int miscompares = 0;
  int n_checks = 0;
  // encoder model and device
  ecl_enc_model u_enc (.clk_sys(clk_sys), .step(step), .dir(dir), .ref_lvl(ref_lvl),
    .sw_lvl(sw_lvl), .enc_a(enc_a), .enc_b(enc_b), .ref_pulse(ref_pulse), .ref_switch(ref_switch));
  ecl_channel DUT (.clk_sys(clk_sys), .rst(rst), .enc_a(enc_a), .enc_b(enc_b),
    .ref_pulse(ref_pulse), .ref_switch(ref_switch), .supply_ok(supply_ok),
    .cfg_unsigned(cfg_unsigned), .cmp_enable(cmp_enable), .word_idx(word_idx),
    .word_wr(word_wr), .word_wdata(word_wdata),
    .word_rdata(word_rdata), .cmp_out(cmp_out));
  // 100 ns clock
  initial begin
    forever #50 clk_sys = ~clk_sys;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : cyc
  task automatic wr(input logic [3:0] i, input logic [15:0] d);
    word_idx = i;
    word_wdata = d;
    word_wr = 1'b1;
    cyc(1);
    word_wr = 1'b0;
    // idle edge so back-to-back writes never re-raise the strobe in one step
    cyc(1);
  endtask : wr
  task automatic rd(input logic [3:0] i);
    word_idx = i;
    cyc(1);
    v = word_rdata;
  endtask : rd
  // 32-bit values go upper word first
  task automatic wr32(input logic [3:0] i, input logic [31:0] d);
    wr(i, d[31:16]);
    wr(i + 4'h1, d[15:0]);
  endtask : wr32
  task automatic rd32(input logic [3:0] i);
    rd(i);
    c[31:16] = v;
    rd(i + 4'h1);
    c[15:0] = v;
  endtask : rd32
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic steps(input int n, input logic d);
    dir = d;
    repeat (n) begin
      step = 1'b1;
      cyc(1);
      step = 1'b0;
      cyc(3);
    end
  endtask : steps
  task automatic t_status();
    steps(1, 1'b0);
    ref_lvl = 1'b1;
    cyc(5);
    rd(IDX_STATUS);
    chk(32'(v[5:0]), 32'({2'h2, enc_a, enc_b, 2'h1}));
    chk(32'({v[15:12], v[9:8]}), 32'h0);
    supply_ok = 1'b0;
    ref_lvl = 1'b0;
    cyc(5);
    rd(IDX_STATUS);
    chk(32'(v[5:0]), 32'({2'h0, enc_a, enc_b, 2'h0}));
    supply_ok = 1'b1;
    wr(IDX_CTRL, 16'hc0ff);
    rd(IDX_CTRL);
    chk(32'(v), 32'h0);
    $display("status test done");
  endtask : t_status
  task automatic t_home();
    wr32(IDX_CFG4, 32'h0);
    wr32(IDX_CFG6, FORCE);
    wr(IDX_CTRL, 16'h0100);
    wr(IDX_CTRL, 16'h1100);
    sw_lvl = 1'b1;
    cyc(LATCH_MAX_CYC);
    rd(IDX_STATUS);
    chk(32'(v[7:6]), 32'h3);
    rd32(IDX_COUNT_HI);
    chk(c, FORCE);
    wr(IDX_CTRL, 16'h0100);
    wr(IDX_CTRL, 16'h3100);
    rd(IDX_STATUS);
    chk(32'(v[ST_HOMED]), 32'h0);
    sw_lvl = 1'b0;
    cyc(LATCH_MAX_CYC);
    rd(IDX_STATUS);
    chk(32'(v[7:6]), 32'h2);
    wr(IDX_CTRL, 16'h0100);
    $display("homing test done");
  endtask : t_home
  task automatic t_latch();
    wr(IDX_CTRL, 16'h0900);
    ref_lvl = 1'b1;
    cyc(LATCH_MAX_CYC);
    rd(IDX_STATUS);
    chk(32'(v[ST_RISE]), 32'h1);
    rd32(IDX_CFG4);
    chk(c, FORCE);
    steps(3, 1'b0);
    ref_lvl = 1'b0;
    cyc(20);
    ref_lvl = 1'b1;
    cyc(LATCH_MAX_CYC);
    rd32(IDX_CFG4);
    chk(c, FORCE);
    steps(3, 1'b1);
    wr(IDX_CTRL, 16'h0100);
    cyc(2);
    rd(IDX_STATUS);
    chk(32'(v[ST_RISE]), 32'h0);
    wr(IDX_CTRL, 16'h0700);
    ref_lvl = 1'b0;
    cyc(LATCH_MAX_CYC);
    rd(IDX_STATUS);
    chk(32'(v[ST_FALL]), 32'h1);
    rd32(IDX_CFG6);
    chk(c, FORCE);
    $display("latch test done");
  endtask : t_latch
  task automatic t_seed();
    wr(IDX_CTRL, 16'h0100);
    ref_lvl = 1'b1;
    cyc(20);
    wr(IDX_CTRL, 16'h0900);
    cyc(LATCH_MAX_CYC);
    rd(IDX_STATUS);
    chk(32'(v[ST_RISE]), 32'h1);
    wr32(IDX_CFG4, 32'h64);
    wr(IDX_CTRL, 16'h0000);
    wr(IDX_CTRL, 16'h0100);
    ref_lvl = 1'b0;
    cyc(20);
    wr(IDX_CTRL, 16'h0900);
    ref_lvl = 1'b1;
    cyc(LATCH_MAX_CYC);
    rd(IDX_STATUS);
    chk(32'(v[ST_RISE]), 32'h0);
    $display("seed test done");
  endtask : t_seed
  // comparator window in both number formats, then latch priority
  task automatic t_cmp();
    cmp_enable = 1'b1;
    wr32(IDX_CFG4, 32'hffff_fff0);
    wr32(IDX_CFG6, 32'h0002_0000);
    cyc(3);
    chk(32'(cmp_out), 32'h1);
    rd(IDX_STATUS);
    chk(32'(v[ST_CMP]), 32'h1);
    cfg_unsigned = 1'b1;
    cyc(3);
    chk(32'(cmp_out), 32'h0);
    wr32(IDX_CFG4, 32'h0001_0000);
    wr32(IDX_CFG6, 32'hffff_fff0);
    cyc(3);
    chk(32'(cmp_out), 32'h1);
    wr32(IDX_CFG4, 32'h0);
    wr(IDX_CTRL, 16'h0000);
    wr(IDX_CTRL, 16'h0100);
    wr(IDX_CTRL, 16'h0900);
    cyc(20);
    rd(IDX_STATUS);
    chk(32'(v[ST_RISE]), 32'h0);
    cmp_enable = 1'b0;
    wr(IDX_CTRL, 16'h0100);
    wr(IDX_CTRL, 16'h0900);
    cyc(20);
    rd(IDX_STATUS);
    chk(32'(v[ST_RISE]), 32'h1);
    rd32(IDX_CFG4);
    chk(c, FORCE);
    cfg_unsigned = 1'b0;
    $display("comparator test done");
  endtask : t_cmp
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : final_report
  // main sequence
  initial begin
    cyc(4);
    rst = 1'b0;
    t_status();
    t_home();
    t_latch();
    t_seed();
    t_cmp();
    final_report();
  end
  // hang guard, tests need about 4000 cycles
  initial begin
    repeat (20000) @(posedge clk_sys);
    miscompares++;
    final_report();
  end
endmodule : tb_top
bind ecl_channel ecl_channel_asserts u_chk (.clk_sys(clk_sys), .rst(rst), .ref_pulse(ref_pulse),
  .ref_switch(ref_switch), .supply_ok(supply_ok), .cmp_enable(cmp_enable), .word_idx(word_idx),
  .word_wr(word_wr), .word_wdata(word_wdata), .word_rdata(word_rdata), .cmp_out(cmp_out));
